// ==== hdl/ckg_consts.vh ====
// Register offsets, field positions, reset values and timing counts of the clock generator control
`ifndef CKG_CONSTS_VH
`define CKG_CONSTS_VH

// ==========================================
// Register byte offsets
`define CKG_MAIN_OSC_REG_OFS     8'h00
`define CKG_MAIN_FREQ_REG_OFS    8'h04
`define CKG_PLL_CONFIG_REG_OFS   8'h08
`define CKG_POWER_STATUS_REG_OFS 8'h0C
`define CKG_IRQ_MASK_REG_OFS     8'h10

// ==========================================
// main_osc_reg fields
`define CKG_MOR_ENABLE_BIT       0
`define CKG_MOR_BYPASS_BIT       1
`define CKG_MOR_COUNT_LSB        8
`define CKG_MOR_COUNT_MSB        15

// ==========================================
// main_freq_reg fields
`define CKG_MFR_COUNT_MSB        15
`define CKG_MFR_DONE_BIT         16

// ==========================================
// pll_config_reg fields
`define CKG_PLR_RATIO_LSB        0
`define CKG_PLR_RATIO_MSB        7
`define CKG_PLR_WAIT_LSB         8
`define CKG_PLR_WAIT_MSB         13
`define CKG_PLR_MUL_LSB          16
`define CKG_PLR_MUL_MSB          26

// ==========================================
// power_status_reg and irq_mask_reg bits
`define CKG_SR_OSC_STABLE_BIT    0
`define CKG_SR_PLL_SETTLED_BIT   2

// ==========================================
// Reset values and timing
`define CKG_RESET_WORD           32'h0000_0000
`define CKG_OSC_PRESCALE         3'h7
`define CKG_FREQ_SLOW_PERIODS    5'h10
`define CKG_RESP_OKAY            2'h0
`define CKG_RESP_SLVERR          2'h2

`endif

// ==== hdl/ckg_down_counter.v ====
// Loadable down-counter that reports one pulse when it reaches zero
`timescale 1ns/1ps

module ckg_down_counter
#(
    parameter WIDTH = 8
)
(
    // Clock and reset
    input  wire             aclk,
    input  wire             aresetn,
    // Control
    input  wire             load,
    input  wire [WIDTH-1:0] load_value,
    input  wire             stop,
    input  wire             tick,
    // Status
    output reg  [WIDTH-1:0] count_r,
    output reg              busy_r,
    output reg              done_r
);

    // ==========================================
    // Counter
    // Load beats stop beats countdown, so a restart is never lost
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_r <= {WIDTH{1'b0}};
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            if (load)
            begin
                count_r <= load_value;
                busy_r  <= 1'b1;
            end
            else if (stop)
                busy_r <= 1'b0;
            else if (busy_r && count_r == {WIDTH{1'b0}})
            begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
            end
            else if (busy_r && tick)
                count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule

// ==== hdl/ckg_clock_ctrl.v ====
// Clock generator control: main oscillator, frequency counter, divider and PLL, AXI4-Lite registers
`timescale 1ns/1ps
`include "ckg_consts.vh"

// Contract
// - Three clocks: slow, main oscillator, divider-plus-PLL; only slow never stops.
// - After reset main oscillator is off and slow clock is selected.
// - Clearing main_osc_enable clears main_osc_stable automatically.
// - Enabling write clears stable, loads 8-bit count, decrements every eight slow periods.
// - Counter at zero sets main_osc_stable; masked bit raises interrupt request.
// - Once stable, frequency counter counts main clock after next slow rising edge.
// - At sixteenth slow falling edge counting stops and freq_measure_done sets.
// - pll_input_ratio 1..255; zero holds divider and PLL outputs low.
// - Reset clears pll_input_ratio, holding PLL input at zero.
// - PLL output frequency is source times (factor plus one) over ratio; the stub drives pll_out_clk_r at source over twice ratio.
// - Zero feedback factor disables PLL; nonzero enables it again.
// - PLL re-enable or parameter change clears pll_settled and loads wait count.
// - Wait counter decrements per slow cycle; zero sets pll_settled, may interrupt.
// - pll_feedback_factor is an 11-bit field, 0 to 2047.
module ckg_clock_ctrl
(
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Clock sources, sampled as synchronous levels
    input  wire        slow_clk,
    input  wire        main_osc_clk,
    // Analog oscillator and PLL controls
    output reg         main_osc_enable_r,
    output reg         osc_bypass_sel_r,
    output reg         pll_enable_r,
    output reg  [7:0]  pll_input_ratio_r,
    output reg  [10:0] pll_feedback_factor_r,
    // Generated clocks and status
    output reg         pll_div_clk_r,
    output reg         pll_out_clk_r,
    output reg         main_clk_valid_r,
    output reg         slow_clk_sel_r,
    output reg         osc_irq_req_r,
    output reg         pll_irq_req_r
);

    // ==========================================
    // Configuration state
    reg [7:0]  startup_tick_count_r;
    reg [5:0]  pll_lock_wait_count_r;
    reg        main_osc_stable_r;
    reg        pll_settled_r;
    reg [1:0]  irq_mask_r;
    reg [15:0] main_freq_count_r;
    reg        freq_measure_done_r;

    // ==========================================
    // Bus slave state
    reg        aw_held_r;
    reg        w_held_r;
    reg [7:0]  aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;

    wire       aw_take = s_axi_awvalid & s_axi_awready;
    wire       w_take  = s_axi_wvalid & s_axi_wready;
    wire       wr_go   = aw_held_r & w_held_r & ~s_axi_bvalid;
    wire       wr_mor  = wr_go && aw_addr_r == `CKG_MAIN_OSC_REG_OFS;
    wire       wr_plr  = wr_go && aw_addr_r == `CKG_PLL_CONFIG_REG_OFS;
    wire       wr_imr  = wr_go && aw_addr_r == `CKG_IRQ_MASK_REG_OFS;
    wire       wr_ok   = wr_mor | wr_plr | wr_imr;

    // Byte-lane merge of the incoming word over the addressed register
    wire [31:0] mor_word = {16'h0000, startup_tick_count_r, 6'h00, osc_bypass_sel_r, main_osc_enable_r};
    wire [31:0] plr_word = {5'h00, pll_feedback_factor_r, 2'h0, pll_lock_wait_count_r, pll_input_ratio_r};
    wire [31:0] strb_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire [31:0] mor_new  = (w_data_r & strb_mask) | (mor_word & ~strb_mask);
    wire [31:0] plr_new  = (w_data_r & strb_mask) | (plr_word & ~strb_mask);

    wire        new_osc_en = mor_new[`CKG_MOR_ENABLE_BIT];
    wire [10:0] new_mul    = plr_new[`CKG_PLR_MUL_MSB:`CKG_PLR_MUL_LSB];
    wire        plr_change = plr_new[26:0] != plr_word[26:0];

    // ==========================================
    // Slow and main clock edge detection
    reg        slow_q_r;
    reg        main_q_r;
    reg [2:0]  osc_presc_r;
    wire       slow_rise = slow_clk & ~slow_q_r;
    wire       slow_fall = ~slow_clk & slow_q_r;
    wire       main_rise = main_osc_clk & ~main_q_r;
    wire       osc_tick  = slow_rise && osc_presc_r == `CKG_OSC_PRESCALE;

    wire       osc_load = wr_mor & new_osc_en;
    wire       osc_stop = wr_mor & ~new_osc_en;
    wire       pll_load = wr_plr & (new_mul != 11'h000) & (plr_change | ~pll_enable_r);
    wire       pll_stop = wr_plr & (new_mul == 11'h000);
    wire       osc_done;
    wire       pll_done;

    // ==========================================
    // Startup and lock-wait counters
    ckg_down_counter #(.WIDTH(8)) u_osc_cnt
    (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .load       (osc_load),
        .load_value (mor_new[`CKG_MOR_COUNT_MSB:`CKG_MOR_COUNT_LSB]),
        .stop       (osc_stop),
        .tick       (osc_tick),
        .count_r    (),
        .busy_r     (),
        .done_r     (osc_done)
    );

    ckg_down_counter #(.WIDTH(8)) u_pll_cnt
    (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .load       (pll_load),
        .load_value ({2'b00, plr_new[`CKG_PLR_WAIT_MSB:`CKG_PLR_WAIT_LSB]}),
        .stop       (pll_stop),
        .tick       (slow_rise),
        .count_r    (),
        .busy_r     (),
        .done_r     (pll_done)
    );

    // ==========================================
    // Register file and oscillator / PLL control
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            main_osc_enable_r     <= 1'b0;
            slow_clk_sel_r        <= 1'b1;
            osc_bypass_sel_r      <= 1'b0;
            startup_tick_count_r  <= 8'h00;
            pll_input_ratio_r     <= 8'h00;
            pll_feedback_factor_r <= 11'h000;
            pll_lock_wait_count_r <= 6'h00;
            pll_enable_r          <= 1'b0;
            irq_mask_r            <= 2'b00;
            main_osc_stable_r     <= 1'b0;
            pll_settled_r         <= 1'b0;
            osc_presc_r           <= 3'h0;
        end
        else
        begin
            slow_clk_sel_r <= ~main_osc_stable_r;
            if (wr_mor)
            begin
                main_osc_enable_r    <= new_osc_en;
                osc_bypass_sel_r     <= mor_new[`CKG_MOR_BYPASS_BIT];
                startup_tick_count_r <= mor_new[`CKG_MOR_COUNT_MSB:`CKG_MOR_COUNT_LSB];
            end
            if (wr_plr)
            begin
                pll_input_ratio_r     <= plr_new[`CKG_PLR_RATIO_MSB:`CKG_PLR_RATIO_LSB];
                pll_lock_wait_count_r <= plr_new[`CKG_PLR_WAIT_MSB:`CKG_PLR_WAIT_LSB];
                pll_feedback_factor_r <= new_mul;
                pll_enable_r          <= new_mul != 11'h000;
            end
            if (wr_imr)
                irq_mask_r <= {w_data_r[`CKG_SR_PLL_SETTLED_BIT], w_data_r[`CKG_SR_OSC_STABLE_BIT]};

            // Prescaler restarts with each enabling write so the first tick is a full eight periods
            if (osc_load)
                osc_presc_r <= 3'h0;
            else if (slow_rise)
                osc_presc_r <= osc_presc_r + 3'h1;

            // A write restarting the wait wins over a completion in the same cycle
            if (osc_load | osc_stop)
                main_osc_stable_r <= 1'b0;
            else if (osc_done)
                main_osc_stable_r <= 1'b1;

            if (pll_load | pll_stop)
                pll_settled_r <= 1'b0;
            else if (pll_done)
                pll_settled_r <= 1'b1;
        end
    end

    // ==========================================
    // Main clock frequency measurement
    reg        freq_armed_r;
    reg        freq_run_r;
    reg [4:0]  fall_cnt_r;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            slow_q_r            <= 1'b0;
            main_q_r            <= 1'b0;
            freq_armed_r        <= 1'b0;
            freq_run_r          <= 1'b0;
            fall_cnt_r          <= 5'h00;
            main_freq_count_r   <= 16'h0000;
            freq_measure_done_r <= 1'b0;
        end
        else
        begin
            slow_q_r <= slow_clk;
            main_q_r <= main_osc_clk;
            if (!main_osc_stable_r)
            begin
                freq_armed_r        <= 1'b1;
                freq_run_r          <= 1'b0;
                fall_cnt_r          <= 5'h00;
                main_freq_count_r   <= 16'h0000;
                freq_measure_done_r <= 1'b0;
            end
            else if (freq_armed_r && slow_rise)
            begin
                freq_armed_r <= 1'b0;
                freq_run_r   <= 1'b1;
            end
            else if (freq_run_r)
            begin
                if (main_rise)
                    main_freq_count_r <= main_freq_count_r + 16'h0001;
                if (slow_fall)
                begin
                    fall_cnt_r <= fall_cnt_r + 5'h01;
                    if (fall_cnt_r + 5'h01 == `CKG_FREQ_SLOW_PERIODS)
                    begin
                        freq_run_r          <= 1'b0;
                        freq_measure_done_r <= 1'b1;
                    end
                end
            end
        end
    end

    // ==========================================
    // Input divider and PLL output stub
    // The multiplier is analog; only the divided source and its validity are modelled here
    reg [7:0]  div_cnt_r;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_cnt_r        <= 8'h00;
            pll_div_clk_r    <= 1'b0;
            pll_out_clk_r    <= 1'b0;
            main_clk_valid_r <= 1'b0;
            osc_irq_req_r    <= 1'b0;
            pll_irq_req_r    <= 1'b0;
        end
        else
        begin
            main_clk_valid_r <= main_osc_stable_r | osc_bypass_sel_r;
            osc_irq_req_r    <= main_osc_stable_r & irq_mask_r[0];
            pll_irq_req_r    <= pll_settled_r & irq_mask_r[1];
            if (pll_input_ratio_r == 8'h00)
            begin
                div_cnt_r     <= 8'h00;
                pll_div_clk_r <= 1'b0;
                pll_out_clk_r <= 1'b0;
            end
            else
            begin
                if (main_rise)
                begin
                    // Toggle every ratio source edges: divided clock period is twice ratio source periods
                    if (div_cnt_r + 8'h01 >= pll_input_ratio_r)
                    begin
                        div_cnt_r     <= 8'h00;
                        pll_div_clk_r <= ~pll_div_clk_r;
                    end
                    else
                        div_cnt_r <= div_cnt_r + 8'h01;
                end
                pll_out_clk_r <= pll_div_clk_r & pll_enable_r & pll_settled_r;
            end
        end
    end

    // ==========================================
    // AXI4-Lite write channel
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= `CKG_RESET_WORD;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CKG_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= ~aw_held_r & ~aw_take & ~wr_go;
            s_axi_wready  <= ~w_held_r & ~w_take & ~wr_go;
            if (aw_take)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_take)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `CKG_RESP_OKAY : `CKG_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================
    // AXI4-Lite read channel
    reg [31:0] rd_word;
    reg        rd_ok;

    always @*
    begin
        rd_ok   = 1'b1;
        rd_word = `CKG_RESET_WORD;
        case ({s_axi_araddr[7:2], 2'b00})
            `CKG_MAIN_OSC_REG_OFS:     rd_word = mor_word;
            `CKG_MAIN_FREQ_REG_OFS:    rd_word = {15'h0000, freq_measure_done_r, main_freq_count_r};
            `CKG_PLL_CONFIG_REG_OFS:   rd_word = plr_word;
            `CKG_POWER_STATUS_REG_OFS: rd_word = {29'h0000_0000, pll_settled_r, 1'b0, main_osc_stable_r};
            `CKG_IRQ_MASK_REG_OFS:     rd_word = {29'h0000_0000, irq_mask_r[1], 1'b0, irq_mask_r[0]};
            default:                   rd_ok   = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `CKG_RESET_WORD;
            s_axi_rresp   <= `CKG_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? `CKG_RESP_OKAY : `CKG_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ==== tb/ckg_clock_ctrl_props.sv ====
// Checker for the clock generator control ports
`timescale 1ns/1ps
module ckg_clock_ctrl_props
(
    // Clock and reset
    input logic        aclk,
    input logic        aresetn,
    // Bus handshakes
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    // Oscillator and PLL side
    input logic        main_osc_enable_r,
    input logic        pll_enable_r,
    input logic [7:0]  pll_input_ratio_r,
    input logic [10:0] pll_feedback_factor_r,
    input logic        pll_div_clk_r,
    input logic        pll_out_clk_r,
    input logic        slow_clk_sel_r,
    input logic        pll_irq_req_r
);
    // ==========================================
    // Properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_answer_a:
        assert property (wr_take |-> ##2 s_axi_bvalid) else $error("write answer late");
    b_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rd_hold_a:
        assert property (rd_take |=> s_axi_rvalid ##0 (s_axi_rready or ##1 $stable(s_axi_rdata)))
        else $error("read answer wrong");
    busy_ready_a:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
    osc_off_a:
        assert property ($fell(main_osc_enable_r) |-> ##[0:2] slow_clk_sel_r) else $error("stable kept");
    stable_en_a:
        assert property (!slow_clk_sel_r |-> main_osc_enable_r || $past(main_osc_enable_r)
            || $past(main_osc_enable_r, 2)) else $error("stable without enable");
    ratio_zero_a:
        assert property ((pll_input_ratio_r == 8'h00) [*2] |-> !pll_div_clk_r && !pll_out_clk_r)
        else $error("clock with zero ratio");
    pll_en_a:
        assert property (pll_enable_r == (pll_feedback_factor_r != 11'h000)) else $error("pll enable wrong");
    out_gate_a:
        assert property (pll_out_clk_r |-> $past(pll_enable_r)) else $error("pll output while off");
    pll_irq_a:
        assert property (pll_irq_req_r |-> pll_enable_r || $past(pll_enable_r)) else $error("lock while off");
endmodule

bind ckg_clock_ctrl ckg_clock_ctrl_props u_props
(
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .main_osc_enable_r(main_osc_enable_r), .pll_enable_r(pll_enable_r),
    .pll_input_ratio_r(pll_input_ratio_r), .pll_feedback_factor_r(pll_feedback_factor_r),
    .pll_div_clk_r(pll_div_clk_r), .pll_out_clk_r(pll_out_clk_r), .slow_clk_sel_r(slow_clk_sel_r),
    .pll_irq_req_r(pll_irq_req_r)
);

// ==== tb/ckg_osc_model.sv ====
// Model of the slow RC oscillator and the main crystal pad
`timescale 1ns/1ps
module ckg_osc_model
#(
    parameter SLOW_HALF = 4,
    parameter MAIN_HALF = 2
)
(
    // Clock
    input  logic aclk,
    // Controls from the block
    input  logic main_osc_enable_r,
    input  logic osc_bypass_sel_r,
    // Clocks to the block
    output logic slow_clk,
    output logic main_osc_clk
);
    int sc = 0;
    int mc = 0;
    initial slow_clk = 1'b0;
    initial main_osc_clk = 1'b0;
    // Slow clock runs free whatever the block asks
    always @(posedge aclk)
    begin
        sc <= (sc == SLOW_HALF - 1) ? 0 : sc + 1;
        if (sc == SLOW_HALF - 1)
            slow_clk <= ~slow_clk;
    end
    // A stopped crystal or absent external clock reads low
    always @(posedge aclk)
    begin
        mc <= (mc == MAIN_HALF - 1) ? 0 : mc + 1;
        if (!(main_osc_enable_r || osc_bypass_sel_r))
            main_osc_clk <= 1'b0;
        else if (mc == MAIN_HALF - 1)
            main_osc_clk <= ~main_osc_clk;
    end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the clock generator control
`timescale 1ns/1ps
`include "ckg_consts.vh"
module tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, slow_clk, main_osc_clk;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic osc_en, byp, pll_enable_r, pll_div_clk_r, pll_out_clk_r, clk_valid, slow_clk_sel_r;
    logic osc_irq_req_r, pll_irq_req_r;
    logic [7:0] pll_input_ratio_r;
    logic [10:0] pll_feedback_factor_r;
    int miscompares = 0;
    int tests_run = 0;
    always #50 aclk = ~aclk;
    ckg_clock_ctrl dut
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .slow_clk(slow_clk),
        .main_osc_clk(main_osc_clk), .main_osc_enable_r(osc_en), .osc_bypass_sel_r(byp),
        .pll_enable_r(pll_enable_r), .pll_input_ratio_r(pll_input_ratio_r),
        .pll_feedback_factor_r(pll_feedback_factor_r), .pll_div_clk_r(pll_div_clk_r),
        .pll_out_clk_r(pll_out_clk_r), .main_clk_valid_r(clk_valid), .slow_clk_sel_r(slow_clk_sel_r),
        .osc_irq_req_r(osc_irq_req_r), .pll_irq_req_r(pll_irq_req_r)
    );
    ckg_osc_model u_osc
    (
        .aclk(aclk), .main_osc_enable_r(osc_en), .osc_bypass_sel_r(byp), .slow_clk(slow_clk),
        .main_osc_clk(main_osc_clk)
    );
    // ==========================================
    // Compare, bus and closing tasks
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task cmp_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
        tests_run++;
        if (^g === 1'bx || g < lo || g > hi)
        begin
            miscompares++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task test_done;
        $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (!ad && awready === 1'b1)
            begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1)
            begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask
    // ==========================================
    // Scenarios
    logic [31:0] d;
    logic [1:0] r;
    logic t;
    int n;
    task t_reset;
        cmp("slow_sel", 1, slow_clk_sel_r);
        cmp("osc_en", 0, {osc_en, byp, clk_valid});
        cmp("ratio", 0, pll_input_ratio_r);
        rd(`CKG_MAIN_OSC_REG_OFS, d, r);
        cmp("mor", `CKG_RESET_WORD, d);
        rd(`CKG_PLL_CONFIG_REG_OFS, d, r);
        cmp("plr", `CKG_RESET_WORD, d);
        $display("Test reset done");
    endtask
    task t_bus;
        wr(8'h14, 32'h0000_0001, r);
        cmp("wr_unmapped", `CKG_RESP_SLVERR, r);
        rd(8'h14, d, r);
        cmp("rd_unmapped", `CKG_RESP_SLVERR, r);
        wr(`CKG_POWER_STATUS_REG_OFS, 32'h0000_0005, r);
        cmp("wr_ro", `CKG_RESP_SLVERR, r);
        wr(`CKG_IRQ_MASK_REG_OFS, 32'h0000_0005, r);
        rd(`CKG_IRQ_MASK_REG_OFS, d, r);
        cmp("mask", 32'h0000_0005, d);
        $display("Test bus done");
    endtask
    task t_osc;
        wr(`CKG_MAIN_OSC_REG_OFS, 32'h0000_0201, r);
        for (n = 0; slow_clk_sel_r !== 1'b0 && n < 400; n++) @(posedge aclk);
        cmp_rng("osc_start", 120, 135, n);
        repeat (2) @(posedge aclk);
        cmp("osc_irq", 1, osc_irq_req_r);
        d = 32'h0000_0000;
        for (n = 0; d[16] !== 1'b1 && n < 100; n++) rd(`CKG_MAIN_FREQ_REG_OFS, d, r);
        cmp("freq_done", 1, d[16]);
        cmp_rng("freq", 30, 33, d[15:0]);
        wr(`CKG_MAIN_OSC_REG_OFS, 32'h0000_0000, r);
        repeat (3) @(posedge aclk);
        cmp("sel_back", 1, slow_clk_sel_r);
        cmp("irq_off", 0, osc_irq_req_r);
        $display("Test oscillator done");
    endtask
    task t_pll;
        wr(`CKG_MAIN_OSC_REG_OFS, 32'h0000_0002, r);
        wr(`CKG_PLL_CONFIG_REG_OFS, 32'h07FF_0403, r);
        cmp("mul", 32'h0000_07FF, pll_feedback_factor_r);
        cmp("pll_on", 1, pll_enable_r);
        cmp("byp_valid", 2'b11, {byp, clk_valid});
        for (n = 0; pll_irq_req_r !== 1'b1 && n < 200; n++) @(posedge aclk);
        cmp_rng("lock", 26, 37, n);
        t = pll_div_clk_r;
        n = 0;
        repeat (96)
        begin
            @(posedge aclk);
            if (pll_div_clk_r !== t)
                n++;
            t = pll_div_clk_r;
        end
        cmp_rng("div_toggles", 7, 9, n);
        wr(`CKG_PLL_CONFIG_REG_OFS, 32'h07FF_0405, r);
        repeat (2) @(posedge aclk);
        cmp("relock", 0, pll_irq_req_r);
        wr(`CKG_PLL_CONFIG_REG_OFS, 32'h0000_0405, r);
        cmp("pll_off", 0, pll_enable_r);
        wr(`CKG_PLL_CONFIG_REG_OFS, 32'h0000_0000, r);
        n = 0;
        repeat (64)
        begin
            @(posedge aclk);
            if (pll_div_clk_r !== 1'b0 || pll_out_clk_r !== 1'b0)
                n++;
        end
        cmp("div_low", 0, n);
        $display("Test pll done");
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_bus;
        t_osc;
        t_pll;
        test_done;
    end
    initial
    begin
        #(100 * 8000);
        miscompares++;
        test_done;
    end
endmodule
